// ===== verilog/port_e_pin_mux.sv
// Notes on behaviour
// - Normal expanded reset: only bus clock alternate
// - Special expanded reset: queue, clock, strobe, direction
// - Peripheral mode: function select unreachable
// - Once in normal; special ignores first write, except the no-bus-clock bit
// - No-data-enable bit picks PE7 function
// - Clock test on PE6, special modes outside single-chip only; queue output overrides
// - Queue status on PE6/PE5 outside single-chip
// - No-bus-clock bit: expanded zero, single-chip writable
// - Single-chip PE4 clock needs visibility or no-stretch
// - Word write updates select and mode together
// - Strobe enable drives PE3, limited modes
// - Tag sampled low on falling bus clock
// - Read/write enable drives PE2 outside single-chip
// - Normal expanded: strobe and direction start off
// - Pullups on inputs only; peripheral keeps only the fixed PE1 pullup
// - Port E pullup pins fixed by group
// - Port A/B pullups off while bus
// - Reduced drive once in normal, special ignores first write; absent in peripheral
// - Reduced drive per port, any function
// - Alternate function overrides direction bit
// - Single-chip reset: GPIO, special keeps clock
// - PE1/PE0 input only, always readable
`include "port_e_mux_consts.svh"
`default_nettype none
module port_e_pin_mux #(
  parameter int ADDR_W = 12
) (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire port_e_mux_pkg::op_mode_t op_mode,
  input  wire logic                     tag_enable,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [7:0]               pe_in,
  input  wire logic [7:0]               pe_data,
  input  wire logic [7:0]               port_e_direction,
  input  wire logic [7:0]               pa_dir,
  input  wire logic [7:0]               pb_dir,
  input  wire logic                     data_enable_n,
  input  wire logic                     clk_test,
  input  wire logic                     queue_status_high,
  input  wire logic                     queue_status_low,
  input  wire logic                     bus_clock,
  input  wire logic                     low_byte_strobe_n,
  input  wire logic                     read_write,
  output logic      [7:0]               pe_out,
  output logic      [7:0]               pe_oe,
  output logic      [7:0]               pe_pullup,
  output logic      [7:0]               pa_pullup,
  output logic      [7:0]               pb_pullup,
  output logic                          pe_reduced,
  output logic                          pa_reduced,
  output logic                          pb_reduced,
  output logic                          low_byte_tag,
  output logic      [7:0]               pe_level
);
  import port_e_mux_pkg::*;

  localparam logic [7:0] ONCE_MASK = `FSEL_ONCE;

  logic [7:0] fsel_reg;
  logic [7:0] fsel_wr_reg;
  logic       no_bus_clock_bit_wr_reg;
  logic       internal_visibility_reg;
  logic       bus_clock_stretch_reg;
  logic [7:0] pullup_control_reg;
  logic [7:0] rdrv_reg;
  logic       rdrv_wr_reg;
  logic       bus_clock_reg;

  logic is_single;
  logic is_special;
  logic is_periph;
  logic is_expanded;
  logic setup;
  logic wr_done;
  logic sel_fsel;
  logic sel_pull;
  logic sel_rdrv;
  logic tag_mode;
  logic clk_fall;
  logic [31:0] rd_next;
  logic [7:0]  out_next;
  logic [7:0]  oe_next;

  function automatic logic once_ok(input logic seen, input logic special);
    return special ? seen : !seen;
  endfunction : once_ok

  function automatic logic [7:0] fsel_reset(input op_mode_t m);
    case (m)
      MODE_NORMAL_SINGLE:      return `FSEL_RST_NSC;
      MODE_SPECIAL_SINGLE:     return `FSEL_RST_SSC;
      MODE_NORMAL_EXP_NARROW,
      MODE_NORMAL_EXP_WIDE:    return `FSEL_RST_NEX;
      MODE_SPECIAL_EXP_NARROW,
      MODE_SPECIAL_EXP_WIDE:   return `FSEL_RST_SEX;
      default:                 return `FSEL_RST_PER;
    endcase
  endfunction : fsel_reset

  assign is_single   = (op_mode == MODE_NORMAL_SINGLE) || (op_mode == MODE_SPECIAL_SINGLE);
  assign is_periph   = (op_mode == MODE_PERIPHERAL);
  assign is_special  = (op_mode == MODE_SPECIAL_SINGLE) || (op_mode == MODE_SPECIAL_EXP_NARROW)
                    || (op_mode == MODE_SPECIAL_EXP_WIDE) || is_periph;
  assign is_expanded = !is_single && !is_periph;

  // Bus decode; peripheral mode removes all three words
  assign setup    = psel && !penable;
  assign wr_done  = psel && penable && pready && pwrite;
  assign sel_fsel = (paddr == `FSEL_OFF) && !is_periph;
  assign sel_pull = (paddr == `PULLUP_OFF) && !is_periph;
  assign sel_rdrv = (paddr == `RDRV_OFF) && !is_periph;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (sel_fsel) begin
      rd_next[7:0] = fsel_reg & `FSEL_MASK;
      rd_next[8+`MODE_INTERNAL_VISIBILITY] = internal_visibility_reg;
      rd_next[8+`MODE_BUS_CLOCK_STRETCH] = bus_clock_stretch_reg;
    end else if (sel_pull) begin
      rd_next[7:0] = pullup_control_reg;
    end else if (sel_rdrv) begin
      rd_next[7:0] = rdrv_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(sel_fsel || sel_pull || sel_rdrv);
      prdata  <= (setup && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // Function select: mode-dependent reset, per-bit write locks
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fsel_reg     <= fsel_reset(op_mode);
      fsel_wr_reg  <= 8'h00;
      no_bus_clock_bit_wr_reg <= 1'b0;
    end else begin
      if (wr_done && sel_fsel && pstrb[0]) begin
        for (int i = 0; i < 8; i++) begin
          if (ONCE_MASK[i]) begin
            fsel_wr_reg[i] <= 1'b1;
            if (once_ok(fsel_wr_reg[i], is_special)) begin
              fsel_reg[i] <= pwdata[i];
            end
          end
        end
        no_bus_clock_bit_wr_reg <= 1'b1;
        if (is_expanded) begin
          fsel_reg[`FSEL_NO_BUS_CLOCK_BIT] <= 1'b0;
        end else if (is_special || !no_bus_clock_bit_wr_reg) begin
          fsel_reg[`FSEL_NO_BUS_CLOCK_BIT] <= pwdata[`FSEL_NO_BUS_CLOCK_BIT];
        end
      end
    end
  end

  // Mode byte shares the word so one write sets all PE4 controls
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      internal_visibility_reg <= `INTERNAL_VISIBILITY_RST;
      bus_clock_stretch_reg <= `BUS_CLOCK_STRETCH_RST;
    end else if (wr_done && sel_fsel && pstrb[1]) begin
      internal_visibility_reg <= pwdata[8+`MODE_INTERNAL_VISIBILITY];
      bus_clock_stretch_reg <= pwdata[8+`MODE_BUS_CLOCK_STRETCH];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pullup_control_reg <= `PULLUP_CONTROL_RST;
    end else if (wr_done && sel_pull && pstrb[0]) begin
      pullup_control_reg <= pwdata[7:0] & `PULLUP_CONTROL_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdrv_reg    <= `RDRV_RST;
      rdrv_wr_reg <= 1'b0;
    end else if (wr_done && sel_rdrv && pstrb[0]) begin
      rdrv_wr_reg <= 1'b1;
      if (once_ok(rdrv_wr_reg, is_special)) begin
        rdrv_reg <= pwdata[7:0] & `RDRV_MASK;
      end
    end
  end

  assign tag_mode = fsel_reg[`FSEL_LOW_STROBE_ENABLE] && tag_enable
                 && ((op_mode == MODE_SPECIAL_EXP_NARROW) || (op_mode == MODE_SPECIAL_EXP_WIDE));
  assign clk_fall = bus_clock_reg && !bus_clock;

  // Pin function selection; GPIO defaults from data and direction
  always_comb begin
    out_next = pe_data;
    oe_next  = port_e_direction & `PE_OUT_PINS;
    if (!fsel_reg[`FSEL_NO_DATA_ENABLE_BIT]) begin
      out_next[7] = data_enable_n;
      oe_next[7]  = 1'b1;
    end
    if (fsel_reg[`FSEL_QUEUE_STATUS_OUTPUT_ENABLE] && !is_single) begin
      out_next[6] = queue_status_high;
      out_next[5] = queue_status_low;
      oe_next[6]  = 1'b1;
      oe_next[5]  = 1'b1;
    end else if (fsel_reg[`FSEL_CLOCK_TEST_OUTPUT_ENABLE] && is_special && !is_single) begin
      out_next[6] = clk_test;
      oe_next[6]  = 1'b1;
    end
    if (!fsel_reg[`FSEL_NO_BUS_CLOCK_BIT] && (is_expanded || internal_visibility_reg || !bus_clock_stretch_reg)) begin
      out_next[4] = bus_clock;
      oe_next[4]  = 1'b1;
    end
    if (fsel_reg[`FSEL_LOW_STROBE_ENABLE] && is_expanded && (op_mode != MODE_NORMAL_EXP_NARROW)) begin
      out_next[3] = low_byte_strobe_n;
      oe_next[3]  = tag_mode ? bus_clock : 1'b1;
    end
    if (fsel_reg[`FSEL_READ_WRITE_PIN_ENABLE] && !is_single) begin
      out_next[2] = read_write;
      oe_next[2]  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pe_out <= 8'h00;
      pe_oe  <= 8'h00;
    end else begin
      pe_out <= out_next;
      pe_oe  <= oe_next;
    end
  end

  // Pullups only on pins currently inputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pe_pullup <= `PE_ALW_PUP;
      pa_pullup <= 8'h00;
      pb_pullup <= 8'h00;
    end else begin
      pe_pullup <= ({8{pullup_control_reg[`PUP_E]}} & `PE_PUP_PINS & ~oe_next) | `PE_ALW_PUP;
      pa_pullup <= {8{pullup_control_reg[`PUP_A] && !is_expanded && !is_periph}} & ~pa_dir;
      pb_pullup <= {8{pullup_control_reg[`PUP_B] && !is_expanded && !is_periph}} & ~pb_dir;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pe_reduced <= 1'b0;
      pa_reduced <= 1'b0;
      pb_reduced <= 1'b0;
    end else begin
      pe_reduced <= rdrv_reg[`RDP_E];
      pa_reduced <= rdrv_reg[`RDP_A];
      pb_reduced <= rdrv_reg[`RDP_B];
    end
  end

  // Tag sampling on falling bus clock; pin levels always readable
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bus_clock_reg <= 1'b0;
      low_byte_tag  <= 1'b0;
      pe_level      <= 8'h00;
    end else begin
      bus_clock_reg <= bus_clock;
      low_byte_tag  <= tag_mode && clk_fall && !pe_in[3];
      pe_level      <= pe_in;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_RESET_NORM_EXP: assert property (
    $rose(nrst) && (op_mode == MODE_NORMAL_EXP_WIDE) |-> fsel_reg == `FSEL_RST_NEX)
    else $error("normal expanded reset value wrong");
  AST_RESET_SPEC_EXP: assert property (
    $rose(nrst) && (op_mode == MODE_SPECIAL_EXP_WIDE) |-> fsel_reg == `FSEL_RST_SEX)
    else $error("special expanded reset value wrong");
  AST_PERIPH_REFUSE: assert property (
    setup && is_periph && (paddr == `FSEL_OFF) |=> pslverr && pready && prdata == 32'h0)
    else $error("peripheral access not refused");
  AST_NORMAL_ONCE: assert property (
    wr_done && sel_fsel && pstrb[0] && !is_special && fsel_wr_reg[`FSEL_READ_WRITE_PIN_ENABLE]
    |=> $stable(fsel_reg[`FSEL_READ_WRITE_PIN_ENABLE]))
    else $error("second normal write changed bit");
  AST_SPECIAL_FIRST: assert property (
    wr_done && sel_fsel && pstrb[0] && is_special && !fsel_wr_reg[`FSEL_LOW_STROBE_ENABLE]
    |=> $stable(fsel_reg[`FSEL_LOW_STROBE_ENABLE]) && fsel_wr_reg[`FSEL_LOW_STROBE_ENABLE])
    else $error("first special write not ignored");
  AST_PE7_ENABLE: assert property (
    !fsel_reg[`FSEL_NO_DATA_ENABLE_BIT] |=> pe_oe[7] && (pe_out[7] == $past(data_enable_n)))
    else $error("PE7 data enable not driven");
  AST_QUEUE_OUT: assert property (
    fsel_reg[`FSEL_QUEUE_STATUS_OUTPUT_ENABLE] && !is_single
    |=> pe_oe[6] && pe_oe[5] && (pe_out[6] == $past(queue_status_high)))
    else $error("queue status not on PE6/PE5");
  AST_NO_BUS_CLOCK_BIT_EXP: assert property (
    is_expanded && $stable(op_mode) ##1 is_expanded |-> !fsel_reg[`FSEL_NO_BUS_CLOCK_BIT])
    else $error("no-bus-clock set in expanded mode");
  AST_PE4_GPIO: assert property (
    is_single && fsel_reg[`FSEL_NO_BUS_CLOCK_BIT] |=> pe_oe[4] == $past(port_e_direction[4]))
    else $error("PE4 not GPIO");
  AST_WORD_WRITE: assert property (
    wr_done && sel_fsel && (pstrb[1:0] == 2'b11) && (op_mode == MODE_SPECIAL_SINGLE)
    |=> (internal_visibility_reg == $past(pwdata[8+`MODE_INTERNAL_VISIBILITY]))
     && (fsel_reg[`FSEL_NO_BUS_CLOCK_BIT] == $past(pwdata[`FSEL_NO_BUS_CLOCK_BIT])))
    else $error("word write did not set PE4 controls");
  AST_TAG: assert property (
    tag_mode && clk_fall && !pe_in[3] |=> low_byte_tag)
    else $error("tag missed");
  AST_PE2_SINGLE: assert property (
    is_single |=> pe_oe[2] == $past(port_e_direction[2]))
    else $error("PE2 alternate in single chip");
  AST_PULL_GROUP: assert property (
    pe_pullup[1] && (pe_pullup[6:4] == 3'b000) && (pe_oe[1:0] == 2'b00))
    else $error("port E pullup grouping wrong");
  AST_PA_BUS: assert property (
    is_expanded |=> pa_pullup == 8'h00)
    else $error("port A pullup while bus");
  AST_RDRV_ONCE: assert property (
    wr_done && sel_rdrv && pstrb[0] && !is_special && rdrv_wr_reg |=> $stable(rdrv_reg))
    else $error("reduced drive rewritten");
  AST_RDRV_SPECIAL: assert property (
    wr_done && sel_rdrv && pstrb[0] && is_special && !rdrv_wr_reg |=> $stable(rdrv_reg))
    else $error("first special reduced drive write taken");
  AST_PERIPH_HOLD: assert property (
    is_periph |=> $stable(fsel_reg))
    else $error("peripheral mode changed function select");
  AST_PE6_CLKTEST: assert property (
    fsel_reg[`FSEL_CLOCK_TEST_OUTPUT_ENABLE] && !fsel_reg[`FSEL_QUEUE_STATUS_OUTPUT_ENABLE] && is_special && !is_single
    |=> pe_oe[6] && (pe_out[6] == $past(clk_test)))
    else $error("clock test not on PE6");
  AST_PE6_NORMAL: assert property (
    !is_special && !fsel_reg[`FSEL_QUEUE_STATUS_OUTPUT_ENABLE] |=> pe_oe[6] == $past(port_e_direction[6]))
    else $error("PE6 alternate in normal mode");
  AST_PE4_EXP: assert property (
    is_expanded |=> pe_oe[4] && (pe_out[4] == $past(bus_clock)))
    else $error("bus clock not on PE4 in expanded mode");
  AST_PE3_STROBE: assert property (
    fsel_reg[`FSEL_LOW_STROBE_ENABLE] && is_expanded && (op_mode != MODE_NORMAL_EXP_NARROW) && !tag_mode
    |=> pe_oe[3] && (pe_out[3] == $past(low_byte_strobe_n)))
    else $error("strobe not on PE3");
  AST_PE3_NARROW: assert property (
    op_mode == MODE_NORMAL_EXP_NARROW |=> pe_oe[3] == $past(port_e_direction[3]))
    else $error("PE3 alternate in narrow mode");
  AST_PE2_READ_WRITE_PIN_ENABLE: assert property (
    fsel_reg[`FSEL_READ_WRITE_PIN_ENABLE] && !is_single |=> pe_oe[2] && (pe_out[2] == $past(read_write)))
    else $error("read/write not on PE2");
  AST_PULL_INPUTS: assert property (
    (pe_pullup & pe_oe) == 8'h00)
    else $error("pullup on driven pin");
  AST_LEVEL: assert property (
    nrst |=> pe_level == $past(pe_in))
    else $error("pin level not readable");
  AST_REDUCED: assert property (
    nrst |=> pe_reduced == $past(rdrv_reg[`RDP_E]))
    else $error("port E reduced drive wrong");

  COV_WORD_WRITE: cover property (wr_done && sel_fsel && (pstrb[1:0] == 2'b11));
  COV_TAG:        cover property (low_byte_tag);
  COV_PERIPH_ERR: cover property (pready && pslverr);
  COV_PIPE_ON:    cover property (pe_oe[6] && pe_oe[5] && !is_single);
  COV_SPECIAL_SINGLE: cover property (wr_done && sel_fsel && (op_mode == MODE_SPECIAL_SINGLE));
endmodule : port_e_pin_mux
`default_nettype wire

// ===== verilog/port_e_mux_consts.svh
`ifndef PORT_E_MUX_CONSTS_SVH
`define PORT_E_MUX_CONSTS_SVH

// Byte offsets
`define FSEL_OFF     12'h000
`define PULLUP_OFF   12'h008
`define RDRV_OFF     12'h00C

// port_e_function_select fields
`define FSEL_NO_DATA_ENABLE_BIT    7
`define FSEL_CLOCK_TEST_OUTPUT_ENABLE   6
`define FSEL_QUEUE_STATUS_OUTPUT_ENABLE   5
`define FSEL_NO_BUS_CLOCK_BIT   4
`define FSEL_LOW_STROBE_ENABLE   3
`define FSEL_READ_WRITE_PIN_ENABLE    2
`define FSEL_MASK    8'hFC
`define FSEL_ONCE    8'hEC

// Mode byte, lane 1 of the function select word
`define MODE_INTERNAL_VISIBILITY    3
`define MODE_BUS_CLOCK_STRETCH    0
`define INTERNAL_VISIBILITY_RST     1'b0
`define BUS_CLOCK_STRETCH_RST     1'b0

// pullup_control and reduced_drive_control fields
`define PUP_E        4
`define PUP_B        1
`define PUP_A        0
`define PULLUP_CONTROL_MASK    8'h13
`define PULLUP_CONTROL_RST     8'h00
`define RDP_E        4
`define RDP_B        1
`define RDP_A        0
`define RDRV_MASK    8'h13
`define RDRV_RST     8'h00

// Port E pullup groups and input-only pins
`define PE_PUP_PINS  8'h8D
`define PE_ALW_PUP   8'h02
`define PE_OUT_PINS  8'hFC

// Function select reset value per operating mode
`define FSEL_RST_NSC 8'h90
`define FSEL_RST_SSC 8'h80
`define FSEL_RST_NEX 8'h80
`define FSEL_RST_SEX 8'hAC
`define FSEL_RST_PER 8'h90

`endif

// ===== verilog/port_e_mux_pkg.sv
`default_nettype none
package port_e_mux_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL_SINGLE,
    MODE_SPECIAL_SINGLE,
    MODE_NORMAL_EXP_NARROW,
    MODE_NORMAL_EXP_WIDE,
    MODE_SPECIAL_EXP_NARROW,
    MODE_SPECIAL_EXP_WIDE,
    MODE_PERIPHERAL
  } op_mode_t;
endpackage : port_e_mux_pkg
`default_nettype wire

// ===== sim/ext_bus_model.sv
`default_nettype none
module ext_bus_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pe_out,
  input  wire logic [7:0] pe_oe,
  input  wire logic [7:0] pe_pullup,
  input  wire logic       tag_req,
  output logic            bus_clock,
  output logic [7:0]      pe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_reg;
  initial begin
    bus_clock = 1'b0;
    float_reg = 8'h5A;
  end
  // Bus clock at half rate; undriven pins without pullup wander each cycle
  always @(posedge ref_clk) begin
    bus_clock <= ~bus_clock;
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pe_in[i] = pe_oe[i] ? pe_out[i] : (pe_pullup[i] ? 1'b1 : float_reg[i]);
    end
    // Tag request pulls PE3 low through the low phase
    if (tag_req && !bus_clock) begin
      pe_in[3] = 1'b0;
    end
  end
endmodule : ext_bus_model
`default_nettype wire

// ===== sim/port_e_pin_function_assignment_bench.sv
`default_nettype none
module port_e_pin_function_assignment_bench;
  timeunit 1ns;
  timeprecision 1ps;
  port_e_mux_pkg::op_mode_t op_mode;
  logic ref_clk, nrst, tag_enable, psel, penable, pwrite, pready, pslverr, tag_req;
  logic data_enable_n, clk_test, queue_status_high, queue_status_low, bus_clock;
  logic low_byte_strobe_n, read_write, pe_reduced, pa_reduced, pb_reduced, low_byte_tag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  pe_in, pe_data, port_e_direction, pa_dir, pb_dir, pe_out, pe_oe;
  logic [7:0]  pe_pullup, pa_pullup, pb_pullup, pe_level;
  int          n_errors, total_checks, cyc;

  port_e_pin_mux port_e_pin_mux_i (.ref_clk(ref_clk), .nrst(nrst), .op_mode(op_mode),
    .tag_enable(tag_enable), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pe_in(pe_in), .pe_data(pe_data),
    .port_e_direction(port_e_direction), .pa_dir(pa_dir), .pb_dir(pb_dir),
    .data_enable_n(data_enable_n), .clk_test(clk_test),
    .queue_status_high(queue_status_high), .queue_status_low(queue_status_low),
    .bus_clock(bus_clock), .low_byte_strobe_n(low_byte_strobe_n),
    .read_write(read_write), .pe_out(pe_out), .pe_oe(pe_oe), .pe_pullup(pe_pullup),
    .pa_pullup(pa_pullup), .pb_pullup(pb_pullup), .pe_reduced(pe_reduced),
    .pa_reduced(pa_reduced), .pb_reduced(pb_reduced), .low_byte_tag(low_byte_tag),
    .pe_level(pe_level));

  ext_bus_model ext_bus_model_i (.ref_clk(ref_clk), .pe_out(pe_out), .pe_oe(pe_oe),
    .pe_pullup(pe_pullup), .tag_req(tag_req), .bus_clock(bus_clock), .pe_in(pe_in));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask : settle

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk("prdata", ex, r);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  task automatic do_reset(input int m);
    @(posedge ref_clk);
    op_mode <= port_e_mux_pkg::op_mode_t'(m);
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic count_tags(output int n);
    n = 0;
    repeat (16) begin
      @(posedge ref_clk);
      if (low_byte_tag === 1'b1) n++;
    end
  endtask : count_tags

  task automatic reset_values;
    logic [7:0] fs [7] = '{8'h90, 8'h80, 8'h80, 8'h80, 8'hAC, 8'hAC, 8'h00};
    logic [7:0] oe [7] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h7C, 8'h7C, 8'h00};
    for (int i = 0; i < 7; i++) begin
      do_reset(i);
      rd(12'h000, {24'h0, fs[i]}, i == 6);
      settle();
      chk("pe_oe", oe[i], pe_oe);
      chk("pe_pullup", 8'h02, pe_pullup);
      if (i == 6) begin
        rd(12'h008, 32'h0, 1'b1);
        rd(12'h00C, 32'h0, 1'b1);
      end
    end
  endtask : reset_values

  task automatic normal_single;
    logic [7:0] p;
    do_reset(0);
    wr(12'h000, 32'h0000_0900, 4'h3);
    rd(12'h000, 32'h0000_0900, 1'b0);
    settle();
    chk("pe_oe", 8'h90, pe_oe);
    wr(12'h000, 32'h0000_0100, 4'h2);
    settle();
    chk("pe_oe", 8'h80, pe_oe);
    wr(12'h000, 32'h0, 4'h2);
    wr(12'h000, 32'h0000_00FC, 4'h1);
    rd(12'h000, 32'h0, 1'b0);
    data_enable_n <= 1'b1;
    settle();
    chk("pe_oe", 8'h90, pe_oe);
    chk("pe_out7", 32'h1, pe_out[7]);
    data_enable_n <= 1'b0;
    port_e_direction <= 8'hFF;
    settle();
    chk("pe_out7", 32'h0, pe_out[7]);
    chk("pe_oe", 8'hFC, pe_oe);
    p = pe_in;
    @(posedge ref_clk);
    chk("pe_level", p, pe_level);
    port_e_direction <= 8'h00;
  endtask : normal_single

  task automatic pull_drive;
    do_reset(0);
    pa_dir <= 8'h0F;
    port_e_direction <= 8'h08;
    wr(12'h008, 32'h13, 4'h1);
    rd(12'h008, 32'h13, 1'b0);
    settle();
    chk("pe_pullup", 8'h87, pe_pullup);
    chk("pa_pullup", 8'hF0, pa_pullup);
    chk("pb_pullup", 8'hFF, pb_pullup);
    chk("reduced", 32'h0, {pe_reduced, pa_reduced, pb_reduced});
    wr(12'h00C, 32'h13, 4'h1);
    wr(12'h00C, 32'h0, 4'h1);
    rd(12'h00C, 32'h13, 1'b0);
    settle();
    chk("reduced", 32'h7, {pe_reduced, pa_reduced, pb_reduced});
    rd(12'h004, 32'h0, 1'b1);
    pa_dir <= 8'h00;
    port_e_direction <= 8'h00;
  endtask : pull_drive

  task automatic special_single;
    do_reset(1);
    wr(12'h000, 32'h0000_0910, 4'h3);
    rd(12'h000, 32'h0000_0990, 1'b0);
    settle();
    chk("pe_oe", 8'h00, pe_oe);
    wr(12'h000, 32'h0000_092C, 4'h3);
    rd(12'h000, 32'h0000_092C, 1'b0);
    settle();
    chk("pe_oe", 8'h90, pe_oe);
    wr(12'h00C, 32'h13, 4'h1);
    rd(12'h00C, 32'h0, 1'b0);
    wr(12'h00C, 32'h13, 4'h1);
    wr(12'h00C, 32'h01, 4'h1);
    rd(12'h00C, 32'h01, 1'b0);
  endtask : special_single

  task automatic normal_exp;
    do_reset(2);
    wr(12'h000, 32'h4C, 4'h1);
    wr(12'h000, 32'h00, 4'h1);
    rd(12'h000, 32'h4C, 1'b0);
    settle();
    chk("pe_oe", 8'h94, pe_oe);
  endtask : normal_exp

  task automatic special_exp;
    int n;
    do_reset(5);
    wr(12'h000, 32'h0, 4'h1);
    rd(12'h000, 32'hAC, 1'b0);
    queue_status_high <= 1'b1;
    wr(12'h000, 32'h70, 4'h1);
    rd(12'h000, 32'h60, 1'b0);
    settle();
    chk("pe_out65", 32'h2, pe_out[6:5]);
    chk("pe_oe", 8'hF0, pe_oe);
    clk_test <= 1'b1;
    queue_status_high <= 1'b0;
    wr(12'h000, 32'h40, 4'h1);
    settle();
    chk("pe_out6", 32'h1, pe_out[6]);
    read_write <= 1'b1;
    low_byte_strobe_n <= 1'b1;
    wr(12'h000, 32'h8C, 4'h1);
    wr(12'h008, 32'h13, 4'h1);
    settle();
    chk("pe_out2", 32'h1, pe_out[2]);
    chk("pe_oe2", 32'h1, pe_oe[2]);
    chk("pe_out3", 32'h1, pe_out[3]);
    chk("pa_pullup", 8'h00, pa_pullup);
    chk("pb_pullup", 8'h00, pb_pullup);
    tag_req <= 1'b1;
    count_tags(n);
    chk("tags_off", 32'h0, n);
    tag_enable <= 1'b1;
    count_tags(n);
    chk("tags_on", 32'h1, n > 0);
    tag_req <= 1'b0;
    tag_enable <= 1'b0;
  endtask : special_exp

  initial begin
    {nrst, tag_enable, psel, penable, pwrite, tag_req} = '0;
    {data_enable_n, clk_test, queue_status_high, queue_status_low} = '0;
    {low_byte_strobe_n, read_write} = '0;
    {n_errors, total_checks, cyc} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pe_data = 8'hA5;
    port_e_direction = 8'h00;
    pa_dir = 8'h00;
    pb_dir = 8'h00;
    op_mode = port_e_mux_pkg::MODE_NORMAL_SINGLE;
    reset_values();
    normal_single();
    special_single();
    pull_drive();
    normal_exp();
    special_exp();
    results();
  end
endmodule : port_e_pin_function_assignment_bench
`default_nettype wire
